// ===== rtl/rfic_pkg.sv
package rfic_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CAUSE = 8'h34;
  localparam logic [7:0] ADDR_SENSE = 8'h35;
  localparam logic [7:0] ADDR_EDGE2 = 8'h36;
  localparam logic [7:0] ADDR_TMASK = 8'h39;
  localparam logic [7:0] ADDR_XFLAG = 8'h3A;
  localparam logic [7:0] ADDR_XMASK = 8'h3B;
  localparam logic [7:0] ADDR_CORE = 8'h3F;

  // Reset cause bit positions
  localparam int BIT_WDOG = 3;
  localparam int BIT_BROWN = 2;
  localparam int BIT_PIN = 1;
  localparam int BIT_POWER = 0;
  localparam logic [3:0] CAUSE_RST = 4'h1;

  // External mask and flag bit positions
  localparam int BIT_LINE1 = 7;
  localparam int BIT_LINE0 = 6;
  localparam int BIT_LINE2 = 5;

  // Timer mask bit positions
  localparam int BIT_TOVF = 7;
  localparam int BIT_TMATCH = 6;

  // Global enable position in the core status register
  localparam int BIT_GIE = 7;

  // Sense control field positions and codes
  localparam int SENSE1_HI = 3;
  localparam int SENSE1_LO = 2;
  localparam int SENSE0_HI = 1;
  localparam int SENSE0_LO = 0;
  localparam int EDGE2_BIT = 0;
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Program counter width and vector addresses
  localparam int PC_W = 13;
  localparam logic [12:0] VEC_LINE0 = 13'h0002;
  localparam logic [12:0] VEC_LINE1 = 13'h0004;
  localparam logic [12:0] VEC_LINE2 = 13'h0006;
  localparam logic [12:0] VEC_TMATCH = 13'h000E;
  localparam logic [12:0] VEC_TOVF = 13'h0012;

  // Sequencing counts in clock cycles
  localparam logic [3:0] ENTRY_CYC = 4'h4;
  localparam logic [3:0] WAKE_CYC = 4'h4;
  localparam logic [3:0] RETURN_CYC = 4'h4;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Interrupt sources, lowest vector first
  typedef enum {SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_TMATCH, SRC_TOVF} rfic_src_t;

  typedef enum {ST_IDLE, ST_ENTRY, ST_VECTOR, ST_RETURN, ST_HOLD} rfic_state_t;

endpackage : rfic_pkg

// ===== rtl/rfic_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reset cause bits 7..4 always read zero.
// - Watchdog cause bit 3 set by watchdog reset, cleared by power-on or zero write.
// - Brown-out cause bit 2 set by brown-out, cleared by power-on or zero write.
// - Pin reset cause bit 1 set by pin reset, cleared by power-on or zero write.
// - Power-on cause bit 0 set by power-on, cleared only by zero write.
// - Taking an interrupt clears global enable; software may set it again.
// - Return from handler sets global enable.
// - Vectoring clears the flag of the source taken.
// - Events set flags even with their enable off; flags stay pending.
// - Pending flags wait for global enable, then serve by priority.
// - Level-sensed request has no flag; seen only while pin condition holds.
// - Entry lasts at least four cycles pushing the 13-bit counter.
// - Entry waits until a multi-cycle instruction finishes.
// - Waking from sleep adds four cycles to entry.
// - Return lasts four cycles: pop counter, stack up two, enable set.
// - After return one main instruction runs before the next entry.
// - Line 1 enabled by mask bit 7, vectors to 004, two sense bits.
// - Line 0 enabled by mask bit 6, vectors to 002, two sense bits.
// - Line 2 enabled by mask bit 5, edge only, one select bit, vector 006.
// - Pin activity triggers even when the pin is driven as an output.
// - External flags 7,6,5 set on event, cleared on entry or write of one.
// - Timer mask bit 7 enables overflow 012, bit 6 match A 00E.
// - Level-sensed enabled line keeps requesting while pin held low.
module rfic_top
  import rfic_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Reset cause events from the reset unit
  input wire logic wdog_reset_evt,
  input wire logic brown_reset_evt,
  input wire logic pin_reset_evt,
  // External request pins
  input wire logic ext_req0,
  input wire logic ext_req1,
  input wire logic ext_req2,
  // Timer flag levels and their hardware clears
  input wire logic wide_timer_overflow_flag,
  input wire logic wide_timer_match_a_flag,
  output logic tovf_ack,
  output logic tmatch_ack,
  // Core handshake
  input wire logic core_ready,
  input wire logic core_sleeping,
  input wire logic return_from_handler,
  output logic entry_busy,
  output logic stack_push,
  output logic vector_go,
  output logic [PC_W-1:0] vector_addr,
  output logic return_busy,
  output logic stack_pop,
  output logic global_enable
);

  // Software-visible register state
  logic [3:0] cause_r;
  logic [3:0] sense_r;
  logic edge2_r;
  logic [7:0] tmask_r;
  logic [2:0] xmask_r;
  logic [2:0] xflag_r;
  logic gie_r;

  // Pin history and read-back holding register
  logic [2:0] pin_prev_r;
  logic [7:0] rdata_r;

  // Sequencer state and the captured grant
  rfic_state_t state_r;
  rfic_src_t src_r;
  logic [3:0] cnt_r;
  logic [PC_W-1:0] vec_r;

  // Registered strobes toward the core and the timer
  logic vgo_r;
  logic push_r;
  logic pop_r;
  logic tovf_ack_r;
  logic tmatch_ack_r;

  // Edge or level trigger for a two-bit sense field
  function automatic logic trig2(input logic [1:0] mode, input logic now, input logic prev);
    // Level mode is gated off by the caller, it never makes an event
    case (mode)
      SENSE_LEVEL: trig2 = !now;
      SENSE_ANY: trig2 = now != prev;
      SENSE_FALL: trig2 = prev && !now;
      SENSE_RISE: trig2 = !prev && now;
      default: trig2 = 1'b0;
    endcase
  endfunction : trig2

  // Write decode shared by several registers
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    wr_hit = w && (a == ofs);
  endfunction : wr_hit

  // Decoded sense modes and level flags
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic lvl0;
  logic lvl1;

  // Per-line events and flag clears
  logic [2:0] evt;
  logic [2:0] xflag_clr_sw;
  logic [2:0] xflag_clr_hw;

  // Requests and the priority pick
  logic [2:0] xreq;
  logic req_tovf;
  logic req_tmatch;
  logic any_req;
  rfic_src_t pick;
  logic [PC_W-1:0] pick_vec;
  logic grant;

  assign mode0 = {sense_r[SENSE0_HI], sense_r[SENSE0_LO]};
  assign mode1 = {sense_r[SENSE1_HI], sense_r[SENSE1_LO]};
  assign lvl0 = mode0 == SENSE_LEVEL;
  assign lvl1 = mode1 == SENSE_LEVEL;

  // Pin is read regardless of its drive direction, so software can self-trigger
  assign evt[0] = !lvl0 && trig2(mode0, ext_req0, pin_prev_r[0]);
  assign evt[1] = !lvl1 && trig2(mode1, ext_req1, pin_prev_r[1]);
  // Line two is edge only; its one select bit picks the polarity
  assign evt[2] = edge2_r ? (!pin_prev_r[2] && ext_req2)
                          : (pin_prev_r[2] && !ext_req2);

  // Requests: level lines bypass the flag entirely
  // Timer flags arrive as levels and are cleared through the ack strobes
  assign xreq[0] = xmask_r[0] && (lvl0 ? !ext_req0 : xflag_r[0]);
  assign xreq[1] = xmask_r[1] && (lvl1 ? !ext_req1 : xflag_r[1]);
  assign xreq[2] = xmask_r[2] && xflag_r[2];
  assign req_tovf = tmask_r[BIT_TOVF] && wide_timer_overflow_flag;
  assign req_tmatch = tmask_r[BIT_TMATCH] && wide_timer_match_a_flag;
  assign any_req = gie_r && (|xreq || req_tovf || req_tmatch);

  // Fixed priority, lowest vector first
  always_comb begin
    // Overflow is the fallback when nothing lower is pending
    pick = SRC_TOVF;
    pick_vec = VEC_TOVF;
    if (xreq[0]) begin
      pick = SRC_LINE0;
      pick_vec = VEC_LINE0;
    end else if (xreq[1]) begin
      pick = SRC_LINE1;
      pick_vec = VEC_LINE1;
    end else if (xreq[2]) begin
      pick = SRC_LINE2;
      pick_vec = VEC_LINE2;
    end else if (req_tmatch) begin
      pick = SRC_TMATCH;
      pick_vec = VEC_TMATCH;
    end
  end

  // Entry only at an instruction boundary, so multi-cycle ops complete first
  assign grant = (state_r == ST_IDLE) && core_ready && any_req;

  // Hardware clear of the external flag taken, on the vectoring cycle
  always_comb begin
    xflag_clr_hw = 3'h0;
    if (state_r == ST_VECTOR) begin
      case (src_r)
        SRC_LINE0: xflag_clr_hw[0] = 1'b1;
        SRC_LINE1: xflag_clr_hw[1] = 1'b1;
        SRC_LINE2: xflag_clr_hw[2] = 1'b1;
        // Timer flags clear through their ack strobes instead
        default: xflag_clr_hw = 3'h0;
      endcase
    end
  end

  // Writing one clears a flag; write bits 6,7,5 map to lines 0,1,2
  assign xflag_clr_sw = wr_hit(reg_addr, ADDR_XFLAG, reg_wr)
                      ? {reg_wdata[BIT_LINE2], reg_wdata[BIT_LINE1], reg_wdata[BIT_LINE0]}
                      : 3'h0;

  // Reset cause flags; power-on flag comes up set, new events beat a clear
  // A write can only clear bits, never set them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_r <= CAUSE_RST;
    end else begin
      if (wr_hit(reg_addr, ADDR_CAUSE, reg_wr)) begin
        cause_r <= cause_r & reg_wdata[3:0];
      end
      if (wdog_reset_evt) begin
        cause_r[BIT_WDOG] <= 1'b1;
      end
      if (brown_reset_evt) begin
        cause_r[BIT_BROWN] <= 1'b1;
      end
      if (pin_reset_evt) begin
        cause_r[BIT_PIN] <= 1'b1;
      end
    end
  end

  // Configuration registers
  // Unused write bits are dropped, except in the timer mask, which keeps all eight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sense_r <= 4'h0;
      edge2_r <= 1'b0;
      tmask_r <= 8'h00;
      xmask_r <= 3'h0;
    end else begin
      if (wr_hit(reg_addr, ADDR_SENSE, reg_wr)) begin
        sense_r <= reg_wdata[3:0];
      end
      if (wr_hit(reg_addr, ADDR_EDGE2, reg_wr)) begin
        edge2_r <= reg_wdata[EDGE2_BIT];
      end
      if (wr_hit(reg_addr, ADDR_TMASK, reg_wr)) begin
        tmask_r <= reg_wdata;
      end
      if (wr_hit(reg_addr, ADDR_XMASK, reg_wr)) begin
        xmask_r <= {reg_wdata[BIT_LINE2], reg_wdata[BIT_LINE1], reg_wdata[BIT_LINE0]};
      end
    end
  end

  // Pin history for edge detection
  // Resets high so idle-high pins show no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_r <= 3'h7;
    end else begin
      pin_prev_r <= {ext_req2, ext_req1, ext_req0};
    end
  end

  // External flags set regardless of enables; set wins over any clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xflag_r <= 3'h0;
    end else begin
      xflag_r <= (xflag_r & ~(xflag_clr_sw | xflag_clr_hw)) | evt;
    end
  end

  // Global enable: cleared on grant, set at end of return, or by software
  // A grant beats a software write landing in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gie_r <= 1'b0;
    end else if (grant) begin
      gie_r <= 1'b0;
    end else if (state_r == ST_RETURN && cnt_r == CNT_ONE) begin
      gie_r <= 1'b1;
    end else if (wr_hit(reg_addr, ADDR_CORE, reg_wr)) begin
      gie_r <= reg_wdata[BIT_GIE];
    end
  end

  // Entry and return sequencer
  // A grant wins over a return seen in the same idle cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      src_r <= SRC_LINE0;
      cnt_r <= 4'h0;
      vec_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (grant) begin
            state_r <= ST_ENTRY;
            src_r <= pick;
            vec_r <= pick_vec;
            cnt_r <= core_sleeping ? ENTRY_CYC + WAKE_CYC : ENTRY_CYC;
          end else if (return_from_handler) begin
            state_r <= ST_RETURN;
            cnt_r <= RETURN_CYC;
          end
        end
        ST_ENTRY: begin
          // Push cycles; the last count launches the vector
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            state_r <= ST_VECTOR;
          end
        end
        ST_VECTOR: begin
          // The taken line's flag clears in this cycle
          state_r <= ST_IDLE;
        end
        ST_RETURN: begin
          // Pop cycles; enable returns on the last one
          cnt_r <= cnt_r - CNT_ONE;
          if (cnt_r == CNT_ONE) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // One main instruction must retire before another entry
          if (core_ready) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Registered core strobes
  // Ack pulses line up with the vector strobe for the timer flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      push_r <= 1'b0;
      pop_r <= 1'b0;
      vgo_r <= 1'b0;
      tovf_ack_r <= 1'b0;
      tmatch_ack_r <= 1'b0;
    end else begin
      push_r <= grant || (state_r == ST_ENTRY && cnt_r != CNT_ONE);
      pop_r <= (state_r == ST_IDLE && !grant && return_from_handler)
            || (state_r == ST_RETURN && cnt_r != CNT_ONE);
      vgo_r <= state_r == ST_ENTRY && cnt_r == CNT_ONE;
      tovf_ack_r <= state_r == ST_ENTRY && cnt_r == CNT_ONE && src_r == SRC_TOVF;
      tmatch_ack_r <= state_r == ST_ENTRY && cnt_r == CNT_ONE && src_r == SRC_TMATCH;
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  // Idle cycles read back zero so stale data never lingers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CAUSE: rdata_r <= {4'h0, cause_r};
        ADDR_SENSE: rdata_r <= {4'h0, sense_r};
        ADDR_EDGE2: rdata_r <= {7'h00, edge2_r};
        ADDR_TMASK: rdata_r <= tmask_r;
        ADDR_XFLAG: rdata_r <= {xflag_r[1], xflag_r[0], xflag_r[2], 5'h00};
        ADDR_XMASK: rdata_r <= {xmask_r[1], xmask_r[0], xmask_r[2], 5'h00};
        ADDR_CORE: rdata_r <= {gie_r, 7'h00};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Outputs straight from their flip-flops
  assign reg_rdata = rdata_r;

  // Entry strobes; busy and push share one register
  assign entry_busy = push_r;
  assign stack_push = push_r;
  assign vector_go = vgo_r;
  assign vector_addr = vec_r;

  // Return strobes; the core steps its stack pointer on each pop
  assign return_busy = pop_r;
  assign stack_pop = pop_r;
  assign global_enable = gie_r;

  // Timer flag clears, in step with the vector strobe
  assign tovf_ack = tovf_ack_r;
  assign tmatch_ack = tmatch_ack_r;

endmodule : rfic_top

`default_nettype wire

// ===== rtl/dummy_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verification/rfic_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rfic_top_asserts
  import rfic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core handshake
  input wire logic core_ready,
  input wire logic core_sleeping,
  input wire logic entry_busy,
  input wire logic vector_go,
  input wire logic [PC_W-1:0] vector_addr,
  input wire logic tovf_ack,
  input wire logic tmatch_ack,
  input wire logic stack_pop,
  input wire logic global_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Entry and return step sequences
  sequence s_entry4; entry_busy [*4] ##1 (vector_go && !entry_busy); endsequence
  sequence s_entry8; entry_busy [*8] ##1 (vector_go && !entry_busy); endsequence
  sequence s_ret; stack_pop [*4] ##1 (global_enable && !stack_pop); endsequence
  property p_rsv; reg_rd && reg_addr == ADDR_CAUSE |=> reg_rdata[7:4] == 4'h0; endproperty
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_wake; $rose(entry_busy) && !$past(core_sleeping) |-> s_entry4; endproperty
  property p_sleep; $rose(entry_busy) && $past(core_sleeping) |-> s_entry8; endproperty
  property p_gie; $rose(entry_busy) |-> !global_enable; endproperty
  property p_ret; $rose(stack_pop) |-> s_ret; endproperty
  property p_gap; $fell(stack_pop) |-> !entry_busy [*2]; endproperty
  property p_ready; $rose(entry_busy) |-> $past(core_ready); endproperty
  property p_tack; vector_go && vector_addr == VEC_TOVF |-> tovf_ack; endproperty
  property p_mack; vector_go && vector_addr == VEC_TMATCH |-> tmatch_ack; endproperty
  a_rsv: assert property (p_rsv) else $error("cause upper bits set");
  a_idle: assert property (p_idle) else $error("read data outside slot");
  a_wake: assert property (p_wake) else $error("awake entry length");
  a_sleep: assert property (p_sleep) else $error("sleep entry length");
  a_gie: assert property (p_gie) else $error("enable kept on entry");
  a_ret: assert property (p_ret) else $error("return sequence wrong");
  a_gap: assert property (p_gap) else $error("entry right after return");
  a_ready: assert property (p_ready) else $error("entry mid instruction");
  a_tack: assert property (p_tack) else $error("overflow not cleared");
  a_mack: assert property (p_mack) else $error("match not cleared");
endmodule : rfic_top_asserts

// Checker rides on every instance of the top
bind rfic_top rfic_top_asserts u_chk (.clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
  .core_ready, .core_sleeping, .entry_busy, .vector_go, .vector_addr, .tovf_ack,
  .tmatch_ack, .stack_pop, .global_enable);
`default_nettype wire

// ===== verification/rfic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfic_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire logic stall,
  input wire logic sleep,
  // Block side
  input wire logic vector_go,
  output logic core_ready,
  output logic core_sleeping,
  output logic return_from_handler
);
  logic [2:0] hcnt_r;
  // Stall models a long instruction still running
  assign core_ready = !stall;
  assign core_sleeping = sleep;
  // Short handler: return three cycles after the vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hcnt_r <= 3'h0;
    else if (vector_go) hcnt_r <= 3'h3;
    else if (hcnt_r != 3'h0) hcnt_r <= hcnt_r - 3'h1;
  end
  assign return_from_handler = hcnt_r == 3'h1;
endmodule : rfic_core_model
`default_nettype wire

// ===== verification/rfic_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rfic_top_tb_top
  import rfic_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic wdog_reset_evt = 1'b0, brown_reset_evt = 1'b0, pin_reset_evt = 1'b0;
  logic ext_req0 = 1'b1, ext_req1 = 1'b1, ext_req2 = 1'b1, stall = 1'b0, sleep = 1'b0;
  logic wide_timer_overflow_flag = 1'b0, wide_timer_match_a_flag = 1'b0;
  logic core_ready, core_sleeping, return_from_handler, entry_busy, stack_push, vector_go;
  logic return_busy, stack_pop, global_enable, tovf_ack, tmatch_ack;
  logic [PC_W-1:0] vector_addr;
  int errors = 0, comparisons = 0;
  logic [7:0] clr_m [4] = '{8'hFD, 8'hFB, 8'hF7, 8'hFE};
  logic [7:0] clr_e [4] = '{8'h0D, 8'h09, 8'h01, 8'h00};

  rfic_top dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wdog_reset_evt, .brown_reset_evt, .pin_reset_evt, .ext_req0, .ext_req1, .ext_req2,
    .wide_timer_overflow_flag, .wide_timer_match_a_flag, .tovf_ack, .tmatch_ack,
    .core_ready, .core_sleeping, .return_from_handler, .entry_busy, .stack_push,
    .vector_go, .vector_addr, .return_busy, .stack_pop, .global_enable);
  rfic_core_model core (.clk, .rst, .stall, .sleep, .vector_go, .core_ready,
    .core_sleeping, .return_from_handler);

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  // Bounded wait for the vector strobe
  task automatic wait_vec(input logic [12:0] e);
    int n;
    n = 0;
    do begin @(posedge clk); #1 n++; end while (vector_go !== 1'b1 && n < 40);
    chk(vector_go, 1'b1);
    chk(vector_addr, e);
  endtask : wait_vec

  task automatic t_cause();
    rd(ADDR_CAUSE, 8'h01);
    @(posedge clk) {wdog_reset_evt, brown_reset_evt, pin_reset_evt} <= 3'h7;
    @(posedge clk) {wdog_reset_evt, brown_reset_evt, pin_reset_evt} <= 3'h0;
    rd(ADDR_CAUSE, 8'h0F);
    // Zero writes clear one cause at a time
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CAUSE, clr_m[i]);
      rd(ADDR_CAUSE, clr_e[i]);
    end
    rd(8'h20, 8'h00);
    rd(ADDR_TMASK, 8'h00);
    rd(ADDR_XFLAG, 8'h00);
  endtask : t_cause

  task automatic t_service();
    wr(ADDR_SENSE, 8'h0A);
    wr(ADDR_EDGE2, 8'h01);
    @(posedge clk) {ext_req0, ext_req1, ext_req2} <= 3'h0;
    @(posedge clk) ext_req2 <= 1'b1;
    rd(ADDR_XFLAG, 8'hE0);
    wr(ADDR_XFLAG, 8'h40);
    rd(ADDR_XFLAG, 8'hA0);
    @(posedge clk) ext_req0 <= 1'b1;
    @(posedge clk) ext_req0 <= 1'b0;
    wr(ADDR_XMASK, 8'hFF);
    rd(ADDR_XMASK, 8'hE0);
    repeat (4) @(posedge clk);
    #1 chk(entry_busy, 1'b0);
    wr(ADDR_CORE, 8'h80);
    repeat (2) @(posedge clk);
    #1 chk(stack_push, 1'b1);
    wait_vec(VEC_LINE0);
    chk(global_enable, 1'b0);
    wait_vec(VEC_LINE1);
    wait_vec(VEC_LINE2);
    repeat (10) @(posedge clk);
    #1 chk(global_enable, 1'b1);
    rd(ADDR_XFLAG, 8'h00);
  endtask : t_service

  task automatic t_level();
    @(posedge clk) {ext_req0, ext_req1} <= 2'h3;
    wr(ADDR_SENSE, 8'h00);
    wr(ADDR_XMASK, 8'h40);
    @(posedge clk) ext_req0 <= 1'b0;
    wait_vec(VEC_LINE0);
    repeat (5) @(posedge clk);
    #1 chk(return_busy, 1'b1);
    rd(ADDR_XFLAG, 8'h00);
    wait_vec(VEC_LINE0);
    @(posedge clk) ext_req0 <= 1'b1;
    repeat (30) @(posedge clk);
    #1 chk(entry_busy, 1'b0);
  endtask : t_level

  task automatic t_timer();
    wr(ADDR_XMASK, 8'h00);
    wr(ADDR_TMASK, 8'hC0);
    rd(ADDR_TMASK, 8'hC0);
    @(posedge clk) {stall, sleep, wide_timer_overflow_flag, wide_timer_match_a_flag} <= 4'hF;
    repeat (6) @(posedge clk);
    #1 chk(entry_busy, 1'b0);
    @(posedge clk) stall <= 1'b0;
    wait_vec(VEC_TMATCH);
    chk(tmatch_ack, 1'b1);
    @(posedge clk) wide_timer_match_a_flag <= 1'b0;
    wait_vec(VEC_TOVF);
    chk(tovf_ack, 1'b1);
    @(posedge clk) wide_timer_overflow_flag <= 1'b0;
  endtask : t_timer

  // Any-change, rising and falling modes set flags with every external mask off
  task automatic t_modes();
    wr(ADDR_SENSE, 8'h07);
    wr(ADDR_EDGE2, 8'h00);
    @(posedge clk) {ext_req0, ext_req1, ext_req2} <= 3'h0;
    @(posedge clk);
    rd(ADDR_XFLAG, 8'hA0);
    wr(ADDR_XFLAG, 8'hA0);
    @(posedge clk) {ext_req0, ext_req1} <= 2'h3;
    @(posedge clk);
    rd(ADDR_XFLAG, 8'hC0);
  endtask : t_modes

  // Power-on reset in mid-run clears the other causes and sets bit 0
  task automatic t_por();
    @(posedge clk) wdog_reset_evt <= 1'b1;
    @(posedge clk) wdog_reset_evt <= 1'b0;
    rd(ADDR_CAUSE, 8'h08);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CAUSE, 8'h01);
  endtask : t_por

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_cause();
    t_service();
    t_level();
    t_timer();
    t_modes();
    t_por();
    report_and_stop();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : rfic_top_tb_top
`default_nettype wire
